// [core/fcb_top.sv]
// Shared byte buffer with watermark alerts and checksum unit, AXI4-Lite.
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module fcb_top
  import fcb_pkg::*;
#(
  parameter int unsigned DEPTH = FCB_DEPTH
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  input  wire logic        int_push_valid,
  input  wire logic [7:0]  int_push_data,
  output logic             int_push_ready,
  input  wire logic        int_pop_valid,
  output logic             int_pop_ready,
  output logic      [7:0]  int_pop_data,
  output logic             irq
);
  typedef struct packed {
    logic [FCB_PTR_W-1:0] wr_ptr;
    logic [FCB_PTR_W-1:0] rd_ptr;
    logic                 head_ok;
    logic                 ovfl;
    logic                 ae_q;
    logic                 af_q;
    logic                 ae_irq;
    logic                 af_irq;
    logic                 done_irq;
    logic                 ae_en;
    logic                 af_en;
    logic                 done_en;
    logic                 irq;
    logic [5:0]           wm;
    fcb_psel_t            psel;
    logic                 msb_first;
    logic [15:0]          crc;
    logic                 crc_busy;
    logic                 crc_ready;
    logic                 aw_held;
    logic [7:0]           awaddr;
    logic                 w_held;
    logic [7:0]           wdata;
    logic                 wlane;
    logic                 bvalid;
    logic [1:0]           bresp;
    fcb_rst_t             rstate;
    logic [7:0]           araddr;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
  } fcb_state_t;

  fcb_state_t st_ff;
  fcb_state_t nxt_st;

  logic [FCB_PTR_W-1:0] fill;
  logic                 full;
  logic                 empty;
  logic                 ae_now;
  logic                 af_now;
  logic                 do_wr;
  fcb_reg_t             wsel;
  fcb_reg_t             rsel;
  logic                 wr_dp;
  logic                 host_push;
  logic                 host_ovfl;
  logic                 flush;
  logic                 rd_dp;
  logic                 host_pop;
  logic                 int_push;
  logic                 int_pop;
  logic                 crc_pop;
  logic                 crc_start;
  logic                 push;
  logic                 pop;
  logic [7:0]           mem_q;
  logic [7:0]           push_data;

  // Bitwise shift of one byte; reflected when bytes enter low bit first.
  function automatic logic [15:0] fcb_crc_byte(input logic [15:0] c,
                                               input logic [7:0]  d,
                                               input logic        msb);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (msb) begin
        fb = r[15] ^ d[7-i];
        r  = {r[14:0], 1'b0} ^ (fb ? FCB_POLY_NORM : 16'h0000);
      end else begin
        fb = r[0] ^ d[i];
        r  = {1'b0, r[15:1]} ^ (fb ? FCB_POLY_REFL : 16'h0000);
      end
    end
    return r;
  endfunction : fcb_crc_byte

  assign fill   = st_ff.wr_ptr - st_ff.rd_ptr;
  assign full   = (fill == FCB_FULL_LVL);
  assign empty  = (fill == '0);
  assign af_now = ((FCB_FULL_LVL - fill) <= {1'b0, st_ff.wm});
  assign ae_now = (fill <= {1'b0, st_ff.wm});

  assign do_wr     = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  assign wsel      = fcb_decode(st_ff.awaddr);
  assign rsel      = fcb_decode(st_ff.araddr);
  assign wr_dp     = do_wr && (wsel == FCB_REG_DATA) && st_ff.wlane;
  assign host_push = wr_dp && !full;
  assign host_ovfl = wr_dp && full;
  assign flush     = do_wr && (wsel == FCB_REG_FILL) && st_ff.wlane &&
                     st_ff.wdata[FCB_FLUSH_BIT];
  assign crc_start = do_wr && (wsel == FCB_REG_CCTL) && st_ff.wlane &&
                     st_ff.wdata[FCB_START_BIT];

  // The head byte is valid one cycle after the pointers settle, so every
  // consumer waits for head_ok; this costs a cycle between pops.
  assign rd_dp    = (st_ff.rstate == FCB_R_WAIT) && (rsel == FCB_REG_DATA);
  assign host_pop = rd_dp && !empty && st_ff.head_ok;
  // Host reads win; the host must keep off the port during a command.
  assign int_pop_ready  = st_ff.head_ok && !empty && !rd_dp;
  assign int_pop        = int_pop_valid && int_pop_ready;
  assign int_push_ready = !full && !wr_dp && !flush;
  assign int_push       = int_push_valid && int_push_ready;
  assign crc_pop  = st_ff.crc_busy && st_ff.head_ok && !empty && !rd_dp &&
                    !int_pop_valid;
  assign push      = host_push || int_push;
  assign pop       = host_pop || int_pop || crc_pop;
  assign push_data = host_push ? st_ff.wdata : int_push_data;
  assign int_pop_data = mem_q;

  fcb_mem #(
    .DEPTH (DEPTH),
    .AW    (FCB_IDX_W),
    .DW    (8)
  ) u_mem (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .we       (push),
    .waddr    (st_ff.wr_ptr[FCB_IDX_W-1:0]),
    .wdata    (push_data),
    .raddr    (st_ff.rd_ptr[FCB_IDX_W-1:0]),
    .rdata_ff (mem_q)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.head_ok = !(push || pop || flush);
    if (flush) begin
      nxt_st.wr_ptr = '0;
      nxt_st.rd_ptr = '0;
      nxt_st.ovfl   = 1'b0;
    end else begin
      if (push) nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
      if (pop) nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
      if (host_ovfl) nxt_st.ovfl = 1'b1;
    end
    nxt_st.ae_q = ae_now;
    nxt_st.af_q = af_now;
    // Write side: address and data are caught in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = s_axi_wdata[7:0];
      nxt_st.wlane  = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
    if (do_wr) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = (wsel == FCB_REG_NONE) ? FCB_SLVERR : FCB_OKAY;
      if (st_ff.wlane) begin
        if (wsel == FCB_REG_IEN) begin
          nxt_st.ae_en   = st_ff.wdata[FCB_AE_BIT];
          nxt_st.af_en   = st_ff.wdata[FCB_AF_BIT];
          nxt_st.done_en = st_ff.wdata[FCB_DONE_BIT];
        end else if (wsel == FCB_REG_CIRQ) begin
          nxt_st.ae_irq = st_ff.ae_irq && !st_ff.wdata[FCB_AE_BIT];
          nxt_st.af_irq = st_ff.af_irq && !st_ff.wdata[FCB_AF_BIT];
        end else if (wsel == FCB_REG_MIRQ) begin
          nxt_st.done_irq = st_ff.done_irq && !st_ff.wdata[FCB_DONE_BIT];
        end else if (wsel == FCB_REG_WM) begin
          nxt_st.wm = st_ff.wdata[FCB_IDX_W-1:0];
        end else if (wsel == FCB_REG_MODE) begin
          nxt_st.psel = st_ff.wdata[FCB_PSEL_LSB +: $bits(fcb_psel_t)];
          nxt_st.msb_first = st_ff.wdata[FCB_MSB_BIT];
        end
      end
    end
    // Alert flags are edge events; a set beats a clear in the same cycle.
    if (ae_now && !st_ff.ae_q) nxt_st.ae_irq = 1'b1;
    if (af_now && !st_ff.af_q) nxt_st.af_irq = 1'b1;
    // Checksum engine drains the buffer one byte per pop.
    if (crc_start) begin
      nxt_st.crc       = fcb_preset(st_ff.psel);
      nxt_st.crc_busy  = 1'b1;
      nxt_st.crc_ready = 1'b0;
    end else if (st_ff.crc_busy) begin
      if (crc_pop) begin
        nxt_st.crc = fcb_crc_byte(st_ff.crc, mem_q, st_ff.msb_first);
      end else if (empty) begin
        nxt_st.crc_busy  = 1'b0;
        nxt_st.crc_ready = 1'b1;
        nxt_st.done_irq  = 1'b1;
      end
    end
    nxt_st.irq = (nxt_st.ae_irq && nxt_st.ae_en) ||
                 (nxt_st.af_irq && nxt_st.af_en) ||
                 (nxt_st.done_irq && nxt_st.done_en);
    // Read side.
    case (st_ff.rstate)
      FCB_R_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_st.araddr = s_axi_araddr;
          nxt_st.rstate = FCB_R_WAIT;
        end
      end
      FCB_R_WAIT: begin
        nxt_st.rresp = FCB_OKAY;
        nxt_st.rdata = '0;
        nxt_st.rstate = FCB_R_RESP;
        if (rsel == FCB_REG_DATA) begin
          if (host_pop) nxt_st.rdata = mem_q;
          else if (!empty) nxt_st.rstate = FCB_R_WAIT;
        end else if (rsel == FCB_REG_FILL) begin
          nxt_st.rdata = {1'b0, fill};
        end else if (rsel == FCB_REG_ERR) begin
          nxt_st.rdata[FCB_AE_BIT] = st_ff.ovfl;
        end else if (rsel == FCB_REG_STAT) begin
          nxt_st.rdata[FCB_AE_BIT]   = ae_now;
          nxt_st.rdata[FCB_AF_BIT]   = af_now;
          nxt_st.rdata[FCB_BUSY_BIT] = st_ff.crc_busy;
          nxt_st.rdata[FCB_RDY_BIT]  = st_ff.crc_ready;
        end else if (rsel == FCB_REG_IEN) begin
          nxt_st.rdata[FCB_AE_BIT]   = st_ff.ae_en;
          nxt_st.rdata[FCB_AF_BIT]   = st_ff.af_en;
          nxt_st.rdata[FCB_DONE_BIT] = st_ff.done_en;
        end else if (rsel == FCB_REG_CIRQ) begin
          nxt_st.rdata[FCB_AE_BIT] = st_ff.ae_irq;
          nxt_st.rdata[FCB_AF_BIT] = st_ff.af_irq;
        end else if (rsel == FCB_REG_WM) begin
          nxt_st.rdata[FCB_IDX_W-1:0] = st_ff.wm;
        end else if (rsel == FCB_REG_MODE) begin
          nxt_st.rdata[FCB_PSEL_LSB +: $bits(fcb_psel_t)] = st_ff.psel;
          nxt_st.rdata[FCB_MSB_BIT] = st_ff.msb_first;
        end else if (rsel == FCB_REG_CRCH) begin
          nxt_st.rdata = st_ff.crc[15:8];
        end else if (rsel == FCB_REG_CRCL) begin
          nxt_st.rdata = st_ff.crc[7:0];
        end else if (rsel == FCB_REG_MIRQ) begin
          nxt_st.rdata[FCB_DONE_BIT] = st_ff.done_irq;
        end else if (rsel == FCB_REG_CCTL) begin
          nxt_st.rdata[FCB_START_BIT] = st_ff.crc_busy;
        end else begin
          nxt_st.rresp = FCB_SLVERR;
        end
      end
      FCB_R_RESP: begin
        if (s_axi_rready) nxt_st.rstate = FCB_R_IDLE;
      end
      default: nxt_st.rstate = FCB_R_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff           <= '0;
      st_ff.ae_q      <= 1'b1;
      st_ff.wm        <= FCB_WM_RST;
      st_ff.rstate    <= FCB_R_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = (st_ff.rstate == FCB_R_IDLE);
  assign s_axi_rvalid  = (st_ff.rstate == FCB_R_RESP);
  assign s_axi_rdata   = {24'h000000, st_ff.rdata};
  assign s_axi_rresp   = st_ff.rresp;
  assign irq           = st_ff.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  fill_bound_a: assert property (fill <= FCB_FULL_LVL)
    else $error("fill level above depth");
  push_adv_a: assert property (host_push && !flush |=>
    st_ff.wr_ptr == $past(st_ff.wr_ptr) + 1'b1)
    else $error("write pointer did not advance");
  pop_data_a: assert property (host_pop |=>
    st_ff.rdata == $past(mem_q) && s_axi_rvalid)
    else $error("data port read returned wrong byte");
  fill_read_a: assert property (
    st_ff.rstate == FCB_R_WAIT && rsel == FCB_REG_FILL |=>
    st_ff.rdata == {1'b0, $past(fill)})
    else $error("fill register read wrong");
  flush_clear_a: assert property (flush |=> empty && !st_ff.ovfl)
    else $error("flush did not clear buffer");
  ovfl_sticky_a: assert property (
    st_ff.ovfl && !flush |=> st_ff.ovfl)
    else $error("overflow flag cleared without flush");
  full_alert_a: assert property (full |-> af_now && !ae_now)
    else $error("almost full missing at full");
  // The status read path must show the comparator, not a stale copy.
  empty_alert_a: assert property (
    st_ff.rstate == FCB_R_WAIT && rsel == FCB_REG_STAT |=>
    st_ff.rdata[FCB_AE_BIT] == ($past(fill) <= $past({1'b0, st_ff.wm})))
    else $error("almost empty status read wrong");
  ae_irq_a: assert property (
    ae_now && !st_ff.ae_q && st_ff.ae_en |=> irq && st_ff.ae_irq)
    else $error("almost empty interrupt missing");
  af_irq_a: assert property (
    af_now && !st_ff.af_q && st_ff.af_en |=> irq && st_ff.af_irq)
    else $error("almost full interrupt missing");
  preset_load_a: assert property (crc_start |=>
    st_ff.crc == fcb_preset($past(st_ff.psel)) && st_ff.crc_busy)
    else $error("checksum preset not loaded");
  crc_done_a: assert property (
    st_ff.crc_busy && empty && !crc_start |=>
    st_ff.crc_ready && st_ff.done_irq && !st_ff.crc_busy)
    else $error("checksum done not flagged");
  ovfl_drop_a: assert property (host_ovfl |=>
    st_ff.ovfl && st_ff.wr_ptr == $past(st_ff.wr_ptr))
    else $error("overflow write not dropped");

  ovfl_seen_c: cover property (host_ovfl);
  crc_end_c: cover property (st_ff.crc_busy ##1 st_ff.crc_ready);
  host_pop_c: cover property (host_pop);
  flush_full_c: cover property (full ##1 flush);
endmodule : fcb_top

// [core/fcb_pkg.sv]
// Constants, register map and types of the byte buffer and checksum block.
// Functional notes
// - One shared buffer of 64 entries, each one byte wide.
// - A host write to the data port stores a byte, advances write pointer.
// - A host read of the data port returns the head byte, advances read.
// - Fill level is write minus read pointer, readable as seven bits.
// - Internal command logic may push and pop the same buffer.
// - Writing flush resets both pointers, fill level and overflow flag.
// - Overflow flag stays set until flush; nothing else clears it.
// - Almost full is one when 64 minus fill is at most the watermark.
// - Almost empty is one when fill is at most the watermark.
// - With its enable set, rising almost empty raises the interrupt.
// - With its enable set, rising almost full raises the interrupt.
// - Checksum starts from one of four presets chosen by two bits.
// - Checksum is 16 bits with polynomial x16 + x12 + x5 + 1.
// - Checksum result is read as separate high and low bytes.
// - With top bit first set, bytes shift in from bit seven.
// - After the buffer is drained, checksum sets ready and done flag.
// - The watermark is a six bit field written by the host.
package fcb_pkg;
  localparam int unsigned FCB_DEPTH     = 64;
  localparam int unsigned FCB_IDX_W     = 6;
  localparam int unsigned FCB_PTR_W     = 7;
  localparam logic [6:0]  FCB_FULL_LVL  = 7'h40;
  localparam logic [5:0]  FCB_WM_RST    = 6'h08;
  localparam logic [7:0]  FCB_OFF_DATA  = 8'h00;
  localparam logic [7:0]  FCB_OFF_FILL  = 8'h04;
  localparam logic [7:0]  FCB_OFF_ERR   = 8'h08;
  localparam logic [7:0]  FCB_OFF_STAT  = 8'h0C;
  localparam logic [7:0]  FCB_OFF_IEN   = 8'h10;
  localparam logic [7:0]  FCB_OFF_CIRQ  = 8'h14;
  localparam logic [7:0]  FCB_OFF_WM    = 8'h18;
  localparam logic [7:0]  FCB_OFF_MODE  = 8'h1C;
  localparam logic [7:0]  FCB_OFF_CRCH  = 8'h20;
  localparam logic [7:0]  FCB_OFF_CRCL  = 8'h24;
  localparam logic [7:0]  FCB_OFF_MIRQ  = 8'h28;
  localparam logic [7:0]  FCB_OFF_CCTL  = 8'h2C;
  localparam int unsigned FCB_FLUSH_BIT = 7;
  localparam int unsigned FCB_AE_BIT    = 0;
  localparam int unsigned FCB_AF_BIT    = 1;
  localparam int unsigned FCB_DONE_BIT  = 2;
  localparam int unsigned FCB_BUSY_BIT  = 4;
  localparam int unsigned FCB_RDY_BIT   = 5;
  localparam int unsigned FCB_MSB_BIT   = 3;
  localparam int unsigned FCB_START_BIT = 0;
  localparam int unsigned FCB_PSEL_LSB  = 0;
  localparam logic [15:0] FCB_PRESET_0  = 16'h0000;
  localparam logic [15:0] FCB_PRESET_1  = 16'h6363;
  localparam logic [15:0] FCB_PRESET_2  = 16'hA671;
  localparam logic [15:0] FCB_PRESET_3  = 16'hFFFF;
  localparam logic [15:0] FCB_POLY_REFL = 16'h8408;
  localparam logic [15:0] FCB_POLY_NORM = 16'h1021;
  localparam logic [1:0]  FCB_OKAY      = 2'h0;
  localparam logic [1:0]  FCB_SLVERR    = 2'h2;

  typedef logic [1:0] fcb_psel_t;
  typedef enum logic [3:0] {
    FCB_REG_DATA, FCB_REG_FILL, FCB_REG_ERR, FCB_REG_STAT, FCB_REG_IEN,
    FCB_REG_CIRQ, FCB_REG_WM, FCB_REG_MODE, FCB_REG_CRCH, FCB_REG_CRCL,
    FCB_REG_MIRQ, FCB_REG_CCTL, FCB_REG_NONE
  } fcb_reg_t;
  typedef enum logic [1:0] {FCB_R_IDLE, FCB_R_WAIT, FCB_R_RESP} fcb_rst_t;

  function automatic fcb_reg_t fcb_decode(input logic [7:0] a);
    if (a == FCB_OFF_DATA) return FCB_REG_DATA;
    else if (a == FCB_OFF_FILL) return FCB_REG_FILL;
    else if (a == FCB_OFF_ERR) return FCB_REG_ERR;
    else if (a == FCB_OFF_STAT) return FCB_REG_STAT;
    else if (a == FCB_OFF_IEN) return FCB_REG_IEN;
    else if (a == FCB_OFF_CIRQ) return FCB_REG_CIRQ;
    else if (a == FCB_OFF_WM) return FCB_REG_WM;
    else if (a == FCB_OFF_MODE) return FCB_REG_MODE;
    else if (a == FCB_OFF_CRCH) return FCB_REG_CRCH;
    else if (a == FCB_OFF_CRCL) return FCB_REG_CRCL;
    else if (a == FCB_OFF_MIRQ) return FCB_REG_MIRQ;
    else if (a == FCB_OFF_CCTL) return FCB_REG_CCTL;
    else return FCB_REG_NONE;
  endfunction : fcb_decode

  function automatic logic [15:0] fcb_preset(input fcb_psel_t s);
    case (s)
      2'h0: return FCB_PRESET_0;
      2'h1: return FCB_PRESET_1;
      2'h2: return FCB_PRESET_2;
      default: return FCB_PRESET_3;
    endcase
  endfunction : fcb_preset
endpackage : fcb_pkg

// [core/fcb_mem.sv]
// Byte storage of the buffer with a registered read port.
`timescale 1ns/1ps
module fcb_mem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW    = 6,
  parameter int unsigned DW    = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end
endmodule : fcb_mem

// [test/fcb_cmd_model.sv]
// Model of the internal command logic that pushes and pops the buffer.
`timescale 1ns/1ps
module fcb_cmd_model (
  input  wire logic       aclk,
  input  wire logic       push_rdy,
  input  wire logic       pop_rdy,
  input  wire logic [7:0] pop_data,
  output logic            push_vld,
  output logic      [7:0] push_data,
  output logic            pop_vld
);
  initial begin
    push_vld  = 1'b0;
    push_data = 8'h00;
    pop_vld   = 1'b0;
  end

  // Moves one byte; dir high pops. A stall past the bound reports hung.
  task automatic xfer(input logic dir, input logic [7:0] b,
                      output logic [7:0] got, output logic hung);
    logic hs;
    hung = 1'b1;
    @(posedge aclk);
    push_vld  <= !dir;
    push_data <= b;
    pop_vld   <= dir;
    for (int n = 0; n < 64 && hung; n++) begin
      @(negedge aclk);
      hs = dir ? (pop_vld & pop_rdy) : (push_vld & push_rdy);
      got = pop_data;
      @(posedge aclk);
      hung = !hs;
    end
    push_vld  <= 1'b0;
    pop_vld   <= 1'b0;
    // A released bus must not keep the last byte, or stale data would pass.
    push_data <= ~b;
  endtask : xfer
endmodule : fcb_cmd_model

// [test/tb_top.sv]
// Self-checking bench of the byte buffer and checksum block.
`timescale 1ns/1ps
module tb_top
  import fcb_pkg::*;
;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, irq;
  logic        push_vld, push_rdy, pop_vld, pop_rdy, hung;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr, araddr, push_data, pop_data, got;
  logic [7:0]  mem [65];
  logic [15:0] c;
  logic [31:0] wdata, rdata, last_rd;
  logic [3:0]  wstrb;
  logic [34:0] e;
  logic [34:0] rq [$];
  logic [1:0]  bq [$];
  int          miscompares, n_compared, n;
  integer      seed;
  logic [15:0] pre [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};

  fcb_top DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .int_push_valid(push_vld),
    .int_push_data(push_data), .int_push_ready(push_rdy),
    .int_pop_valid(pop_vld), .int_pop_ready(pop_rdy),
    .int_pop_data(pop_data), .irq(irq)
  );
  fcb_cmd_model u_cmd (
    .aclk(aclk), .push_rdy(push_rdy), .pop_rdy(pop_rdy),
    .pop_data(pop_data), .push_vld(push_vld), .push_data(push_data),
    .pop_vld(pop_vld)
  );

  task automatic chk(input string nm, input logic [34:0] s,
                     input logic [34:0] x);
    n_compared++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic conclude();
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic hang();
    miscompares++;
    conclude();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = FCB_OKAY);
    logic ah, wh, bh;
    int k;
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      @(posedge aclk);
      awvalid <= awvalid & !ah;
      wvalid  <= wvalid & !wh;
      if (bh) break;
    end
    bready <= 1'b0;
    if (k == 99) hang();
  endtask : wr

  // The note goes on the queue first; the monitor compares on the answer.
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = FCB_OKAY, input logic ck = 1'b1);
    logic ah, go;
    int k;
    rq.push_back({ck, r, d});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(negedge aclk);
      ah = arvalid & arready;
      go = rvalid;
      @(posedge aclk);
      arvalid <= arvalid & !ah;
      if (go) break;
    end
    rready <= 1'b0;
    if (k == 99) hang();
    #1;
  endtask : rd

  function automatic logic [15:0] crc_of(input logic [15:0] s,
                                         input logic [7:0] b, input logic m);
    for (int i = 0; i < 8; i++) begin
      if (m) s = (s[15] ^ b[7-i]) ? ({s[14:0], 1'b0} ^ 16'h1021)
                                  : {s[14:0], 1'b0};
      else s = (s[0] ^ b[i]) ? ((s >> 1) ^ 16'h8408) : (s >> 1);
    end
    return s;
  endfunction : crc_of

  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      last_rd = rdata;
      if (e[34]) chk("read", {rresp, rdata}, e[33:0]);
    end
    if (bvalid && bready) chk("bresp", bresp, bq.pop_front());
  end

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    #200000;
    hang();
  end

  initial begin
    seed = 32'h4F35;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, last_rd} = '0;
    wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FCB_OFF_FILL, 32'h0);
    rd(FCB_OFF_STAT, 32'h1);
    rd(FCB_OFF_WM, 32'h8);
    rd(8'h30, 32'h0, FCB_SLVERR);
    wr(8'h30, 32'h0, FCB_SLVERR);
    wr(FCB_OFF_WM, 32'hFF);
    rd(FCB_OFF_WM, 32'h3F);
    wr(FCB_OFF_WM, 32'h4);
    // A write with its low lane disabled must leave the register alone.
    wstrb <= 4'h0;
    wr(FCB_OFF_WM, 32'h3F);
    wstrb <= 4'hF;
    rd(FCB_OFF_WM, 32'h4);
    wr(FCB_OFF_IEN, 32'h3);
    for (int i = 0; i < 65; i++) begin
      mem[i] = 8'($random(seed));
      if (i == 59) rd(FCB_OFF_STAT, 32'h0);
      if (i == 59) chk("irq", irq, 1'b0);
      wr(FCB_OFF_DATA, {24'h0, mem[i]});
    end
    rd(FCB_OFF_FILL, 32'h40);
    rd(FCB_OFF_ERR, 32'h1);
    rd(FCB_OFF_STAT, 32'h2);
    rd(FCB_OFF_CIRQ, 32'h2);
    wr(FCB_OFF_CIRQ, 32'h2);
    for (int i = 0; i < 64; i++) begin
      if (i == 60) rd(FCB_OFF_STAT, 32'h1);
      if (i == 60) rd(FCB_OFF_CIRQ, 32'h1);
      if (i == 60) chk("irq", irq, 1'b1);
      rd(FCB_OFF_DATA, {24'h0, mem[i]});
    end
    rd(FCB_OFF_DATA, 32'h0);
    rd(FCB_OFF_ERR, 32'h1);
    wr(FCB_OFF_DATA, 32'h11);
    rd(FCB_OFF_ERR, 32'h1);
    wr(FCB_OFF_FILL, 32'h80);
    rd(FCB_OFF_FILL, 32'h0);
    rd(FCB_OFF_ERR, 32'h0);
    wr(FCB_OFF_DATA, 32'h22);
    rd(FCB_OFF_DATA, 32'h22);
    wr(FCB_OFF_IEN, 32'h0);
    wr(FCB_OFF_CIRQ, 32'h3);
    // The host keeps off the data port while the command logic moves bytes.
    u_cmd.xfer(1'b0, 8'h5A, got, hung);
    chk("push", hung, 1'b0);
    rd(FCB_OFF_DATA, 32'h5A);
    wr(FCB_OFF_DATA, 32'hC3);
    u_cmd.xfer(1'b1, 8'h00, got, hung);
    chk("pop", {hung, got}, 9'h0C3);
    for (int k = 0; k < 8; k++) begin
      wr(FCB_OFF_FILL, 32'h80);
      c = pre[k % 4];
      for (int i = 0; i < 3; i++) begin
        mem[i] = 8'($random(seed));
        c = crc_of(c, mem[i], k[2]);
        wr(FCB_OFF_DATA, {24'h0, mem[i]});
      end
      wr(FCB_OFF_MODE, {28'h0, k[2], 1'b0, k[1:0]});
      wr(FCB_OFF_IEN, 32'h4);
      wr(FCB_OFF_CCTL, 32'h1);
      last_rd = 32'h0;
      for (n = 0; n < 60 && !last_rd[5]; n++)
        rd(FCB_OFF_STAT, 32'h0, FCB_OKAY, 1'b0);
      if (n == 60) hang();
      rd(FCB_OFF_CRCH, {24'h0, c[15:8]});
      rd(FCB_OFF_CRCL, {24'h0, c[7:0]});
      rd(FCB_OFF_MIRQ, 32'h4);
      chk("irq", irq, 1'b1);
      wr(FCB_OFF_MIRQ, 32'h4);
    end
    conclude();
  end
endmodule : tb_top
